// [src/i2m_brg.sv]
// bit-rate counter: reload, count down at twice the instruction rate, stop
`timescale 1ns/100ps
`include "i2m_defines.svh"
module i2m_brg (
	input  wire logic pclk,
	input  wire logic presetn,
	i2m_brg_if.cnt    brg
);
	logic [1:0] div_reg;
	logic       tick;
	logic [6:0] count_reg;
	logic       active_reg;

	// tick divider: 40 MHz down to the 20 MHz count rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_reg <= 2'h0;
		else if (div_reg == 2'(`I2M_TICK_CYCLES - 1))
			div_reg <= 2'h0;
		else
			div_reg <= div_reg + 2'h1;
	end
	assign tick = (div_reg == 2'(`I2M_TICK_CYCLES - 1)); // [RULE2]

	// rollover = reload+1 ticks; zero reload never times out early
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg  <= 7'h00;
			active_reg <= 1'b0;
		end else if (brg.load) begin
			count_reg  <= brg.reload; // [RULE4]
			active_reg <= 1'b1;
		end else if (active_reg && tick) begin
			if (count_reg == 7'h00)
				active_reg <= 1'b0; // [RULE22]
			else
				count_reg <= count_reg - 7'h01; // [RULE22]
		end
	end
	// a load in the timeout cycle starts the next rollover; masking it here would loop through the engine
	assign brg.timeout = active_reg && tick && (count_reg == 7'h00);
	assign brg.active  = active_reg;

	a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
		tick |=> !tick) else $error("count tick faster than half rate");
	a_timeout_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
		brg.timeout && !brg.load |=> !active_reg ##1 !brg.timeout) else $error("counter runs past zero");
endmodule : i2m_brg

// [src/i2m_brg_if.sv]
// carrier between the engine and its bit-rate counter
`timescale 1ns/100ps
interface i2m_brg_if;
	logic       load;
	logic [6:0] reload;
	logic       timeout;
	logic       active;
	modport ctl (output load, output reload, input timeout, input active);
	modport cnt (input load, input reload, output timeout, output active);
endinterface : i2m_brg_if

// [src/i2m_defines.svh]
// constants for the i2c master engine: register map, field positions, timing
// Contract
// [RULE1] counter waits for clock high, then reloads
// [RULE2] clock period equals two counter rollovers
// [RULE3] 1 MHz needs fast clock, reload 03h
// [RULE4] each instance keeps its own reload value
// [RULE5] start request with lines high starts count
// [RULE6] second rollover ends start, data held low
// [RULE7] start collision flags event, returns idle
// [RULE8] buffer write during start sets write collision
// [RULE9] low control bits locked during pending condition
// [RULE10] restart accepted only when engine idle
// [RULE11] restart: clock low, release data, rollover
// [RULE12] restart: both high, data low, clear request
// [RULE13] start-seen immediate, event after timeout
// [RULE14] restart collision on data low or clock
// [RULE15] buffer write during restart sets write collision
// [RULE16] software writes address after restart event
// [RULE17] buffer write sets full flag, starts sending
// [RULE18] data changes with clock low, rollover phases
// [RULE19] eighth falling edge clears full, releases data
// [RULE20] ninth falling edge samples acknowledge status
// [RULE21] after ninth clock: event flag, counter stops
// [RULE22] counter counts down, stops, two ticks
// [RULE23] software clears write collision flag itself
`ifndef I2M_DEFINES_SVH
`define I2M_DEFINES_SVH
// register byte offsets
`define I2M_OFF_RELOAD   8'h00
`define I2M_OFF_CTRL2    8'h04
`define I2M_OFF_STATUS   8'h08
`define I2M_OFF_BUFFER   8'h0c
`define I2M_OFF_EVENTS   8'h10
// control register 2 fields
`define I2M_C2_START     0
`define I2M_C2_RESTART   1
`define I2M_C2_ACK_RECEIVED_STATUS   6
`define I2M_C2_LOCK_MASK 5'h1f
// status register fields
`define I2M_ST_FULL      0
`define I2M_ST_START     3
// event register fields, write one to clear
`define I2M_EV_PORT      0
`define I2M_EV_COLL      1
`define I2M_EV_WRITE_COLLISION_FLAG      2
// reset value and bit counter values
`define I2M_RELOAD_RST   7'h09
`define I2M_BIT_LAST     4'h8
`define I2M_BIT_EIGHTH   4'h7
// timing: pclk period and counter tick period in ns
`define I2M_PCLK_NS      25
`define I2M_TICK_NS      50
`define I2M_TICK_CYCLES  (`I2M_TICK_NS / `I2M_PCLK_NS)
`endif

// [src/i2m_pkg.sv]
// types of the i2c master engine
package i2m_pkg;
	typedef enum logic [3:0] {
		IDLE, ST_WAIT, ST_HOLD, RS_LOW, RS_REL, RS_HWAIT, RS_SETUP, RS_HOLD,
		TX_LOW, TX_HWAIT, TX_HIGH
	} i2m_state_type;
endpackage : i2m_pkg

// [src/i2m_top.sv]
// i2c master engine: apb registers, start, repeated start and byte transmit
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "i2m_defines.svh"
module i2m_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bus_clock_pin_in,
	output logic             bus_clock_pin_out,
	output logic             bus_clock_pin_oe,
	input  wire logic        bus_data_pin_in,
	output logic             bus_data_pin_out,
	output logic             bus_data_pin_oe
);
	i2m_pkg::i2m_state_type state_reg;
	i2m_brg_if              brg ();

	logic [6:0] rate_reload_reg;
	logic       start_req_reg;
	logic       restart_req_reg;
	logic       ack_status_reg;
	logic       full_reg;
	logic       start_seen_reg;
	logic [7:0] buffer_reg;
	logic [3:0] bit_reg;
	logic       port_event_reg;
	logic       coll_event_reg;
	logic       write_collision_flag_reg;
	logic       scl_drv_reg;
	logic       sda_drv_reg;
	logic       scl_prev_reg;
	logic       sda_prev_reg;
	logic [31:0] rdata_next;
	logic       wr_access;
	logic       mapped;
	logic       cond_busy;
	logic       engine_busy;
	logic       buf_wr;
	logic       ctrl_wr;
	logic       ev_wr;
	logic       both_high;
	logic       both_low;
	logic       collide;
	logic       start_done;
	logic       restart_done;
	logic       byte_done;
	logic       restart_go;

	i2m_brg i2m_brg_i (
		.pclk    (pclk),
		.presetn (presetn),
		.brg     (brg.cnt)
	);

	// address decode; zero wait states, so pready just follows the access phase
	function automatic logic is_mapped(input logic [7:0] a);
		return (a == `I2M_OFF_RELOAD) || (a == `I2M_OFF_CTRL2) || (a == `I2M_OFF_STATUS) ||
			(a == `I2M_OFF_BUFFER) || (a == `I2M_OFF_EVENTS);
	endfunction : is_mapped
	assign mapped    = is_mapped(paddr);
	assign pready    = psel && penable;
	assign pslverr   = psel && penable && !mapped;
	assign wr_access = psel && penable && pwrite && mapped;
	assign buf_wr    = wr_access && (paddr == `I2M_OFF_BUFFER);
	assign ctrl_wr   = wr_access && (paddr == `I2M_OFF_CTRL2);
	assign ev_wr     = wr_access && (paddr == `I2M_OFF_EVENTS);

	// engine condition summary
	assign cond_busy   = start_req_reg || restart_req_reg;
	assign engine_busy = cond_busy || (state_reg != i2m_pkg::IDLE);
	assign both_high   = bus_clock_pin_in && bus_data_pin_in;
	assign both_low    = !bus_clock_pin_in && !bus_data_pin_in;
	assign restart_go  = ctrl_wr && pwdata[`I2M_C2_RESTART] && !engine_busy; // [RULE10]

	// collision detection across start and restart phases
	always_comb begin
		collide = 1'b0;
		case (state_reg)
			i2m_pkg::IDLE:     collide = start_req_reg && both_low; // [RULE7]
			i2m_pkg::ST_WAIT:  collide = !bus_clock_pin_in ||
				(brg.timeout && !bus_data_pin_in); // [RULE7]
			i2m_pkg::RS_REL:   collide = brg.timeout && !bus_data_pin_in; // [RULE14]
			i2m_pkg::RS_HWAIT: collide = bus_clock_pin_in && !bus_data_pin_in; // [RULE14]
			i2m_pkg::RS_SETUP: collide = !bus_clock_pin_in || !bus_data_pin_in; // [RULE14]
			default:           collide = 1'b0;
		endcase
	end
	assign start_done   = (state_reg == i2m_pkg::ST_HOLD) && brg.timeout;
	assign restart_done = (state_reg == i2m_pkg::RS_HOLD) && brg.timeout;
	assign byte_done    = (state_reg == i2m_pkg::TX_HIGH) && brg.timeout && (bit_reg == `I2M_BIT_LAST);

	// counter load points; clock arbitration holds off every high-phase load
	always_comb begin
		brg.load   = 1'b0;
		brg.reload = rate_reload_reg; // [RULE3]
		case (state_reg)
			i2m_pkg::IDLE:     brg.load = (start_req_reg && both_high) || buf_wr && !engine_busy; // [RULE5] [RULE17]
			i2m_pkg::ST_WAIT:  brg.load = brg.timeout && both_high; // [RULE6]
			i2m_pkg::RS_LOW: begin
				brg.load   = !bus_clock_pin_in;
				brg.reload = {1'b0, rate_reload_reg[5:0]}; // [RULE11]
			end
			i2m_pkg::RS_HWAIT: brg.load = bus_clock_pin_in && bus_data_pin_in; // [RULE1] [RULE12]
			i2m_pkg::RS_SETUP: brg.load = brg.timeout && both_high; // [RULE12]
			i2m_pkg::TX_HWAIT: brg.load = bus_clock_pin_in; // [RULE1]
			i2m_pkg::TX_HIGH:  brg.load = brg.timeout && (bit_reg != `I2M_BIT_LAST); // [RULE18]
			default:           brg.load = 1'b0;
		endcase
	end

	// main sequencer and line drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= i2m_pkg::IDLE;
			scl_drv_reg <= 1'b0;
			sda_drv_reg <= 1'b0;
			bit_reg     <= 4'h0;
		end else if (collide) begin
			state_reg   <= i2m_pkg::IDLE; // [RULE7] [RULE14]
			scl_drv_reg <= 1'b0;
			sda_drv_reg <= 1'b0;
		end else begin
			case (state_reg)
				i2m_pkg::IDLE: begin
					if (start_req_reg && both_high) begin
						state_reg <= i2m_pkg::ST_WAIT; // [RULE5]
					end else if (restart_go) begin
						state_reg   <= i2m_pkg::RS_LOW;
						scl_drv_reg <= 1'b1; // [RULE11]
					end else if (buf_wr && !engine_busy) begin
						state_reg   <= i2m_pkg::TX_LOW; // [RULE17]
						scl_drv_reg <= 1'b1;
						bit_reg     <= 4'h0;
					end
				end
				i2m_pkg::ST_WAIT: if (brg.timeout) begin
					state_reg   <= i2m_pkg::ST_HOLD;
					sda_drv_reg <= 1'b1; // [RULE5]
				end
				i2m_pkg::ST_HOLD: if (brg.timeout)
					state_reg <= i2m_pkg::IDLE; // [RULE6]
				i2m_pkg::RS_LOW: if (!bus_clock_pin_in) begin
					state_reg   <= i2m_pkg::RS_REL;
					sda_drv_reg <= 1'b0; // [RULE11]
				end
				i2m_pkg::RS_REL: if (brg.timeout) begin
					state_reg   <= i2m_pkg::RS_HWAIT;
					scl_drv_reg <= 1'b0; // [RULE11]
				end
				i2m_pkg::RS_HWAIT: if (bus_clock_pin_in)
					state_reg <= i2m_pkg::RS_SETUP;
				i2m_pkg::RS_SETUP: if (brg.timeout) begin
					state_reg   <= i2m_pkg::RS_HOLD;
					sda_drv_reg <= 1'b1; // [RULE12]
				end
				i2m_pkg::RS_HOLD: if (brg.timeout)
					state_reg <= i2m_pkg::IDLE; // [RULE12]
				i2m_pkg::TX_LOW: begin
					// data moves only once the clock is seen low
					if (!bus_clock_pin_in)
						sda_drv_reg <= (bit_reg == `I2M_BIT_LAST) ? 1'b0 :
							!buffer_reg[3'(`I2M_BIT_EIGHTH - bit_reg[2:0])]; // [RULE18] [RULE19]
					if (brg.timeout) begin
						state_reg   <= i2m_pkg::TX_HWAIT;
						scl_drv_reg <= 1'b0; // [RULE18]
					end
				end
				i2m_pkg::TX_HWAIT: if (bus_clock_pin_in)
					state_reg <= i2m_pkg::TX_HIGH;
				i2m_pkg::TX_HIGH: if (brg.timeout) begin
					scl_drv_reg <= 1'b1;
					if (bit_reg == `I2M_BIT_LAST) begin
						state_reg   <= i2m_pkg::IDLE; // [RULE21]
						sda_drv_reg <= 1'b0;
					end else begin
						state_reg <= i2m_pkg::TX_LOW;
						bit_reg   <= bit_reg + 4'h1;
					end
				end
				default: state_reg <= i2m_pkg::IDLE;
			endcase
		end
	end

	// request bits: software sets, hardware clears on completion or collision
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_req_reg   <= 1'b0;
			restart_req_reg <= 1'b0;
		end else if (collide || start_done || restart_done) begin
			start_req_reg   <= 1'b0; // [RULE6] [RULE12]
			restart_req_reg <= 1'b0;
		end else if (ctrl_wr && !cond_busy) begin
			// no command queueing: a pending condition locks the low bits
			start_req_reg   <= pwdata[`I2M_C2_START] && (state_reg == i2m_pkg::IDLE); // [RULE9]
			restart_req_reg <= restart_go; // [RULE10]
		end
	end

	// software-side registers: reload value and transmit buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_reload_reg <= `I2M_RELOAD_RST;
			buffer_reg      <= 8'h00;
		end else begin
			if (wr_access && (paddr == `I2M_OFF_RELOAD))
				rate_reload_reg <= pwdata[6:0]; // [RULE4]
			if (buf_wr && !engine_busy)
				buffer_reg <= pwdata[7:0]; // [RULE8] [RULE15]
		end
	end

	// status: full flag, acknowledge status, start seen on the lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_reg       <= 1'b0;
			ack_status_reg <= 1'b0;
			start_seen_reg <= 1'b0;
			scl_prev_reg   <= 1'b1;
			sda_prev_reg   <= 1'b1;
		end else begin
			scl_prev_reg <= bus_clock_pin_in;
			sda_prev_reg <= bus_data_pin_in;
			if (buf_wr && !engine_busy)
				full_reg <= 1'b1; // [RULE17]
			else if (state_reg == i2m_pkg::TX_HIGH && brg.timeout && bit_reg == `I2M_BIT_EIGHTH)
				full_reg <= 1'b0; // [RULE19]
			if (byte_done)
				ack_status_reg <= bus_data_pin_in; // [RULE20]
			// falling data with clock high is a start, rising is a stop
			if (scl_prev_reg && bus_clock_pin_in && sda_prev_reg && !bus_data_pin_in)
				start_seen_reg <= 1'b1; // [RULE13]
			else if (scl_prev_reg && bus_clock_pin_in && !sda_prev_reg && bus_data_pin_in)
				start_seen_reg <= 1'b0;
		end
	end

	// sticky event flags; a hardware set beats a same-cycle software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_event_reg <= 1'b0;
			coll_event_reg <= 1'b0;
			write_collision_flag_reg       <= 1'b0;
		end else begin
			if (start_done || restart_done || byte_done)
				port_event_reg <= 1'b1; // [RULE13] [RULE21]
			else if (ev_wr && pwdata[`I2M_EV_PORT])
				port_event_reg <= 1'b0;
			if (collide)
				coll_event_reg <= 1'b1; // [RULE7]
			else if (ev_wr && pwdata[`I2M_EV_COLL])
				coll_event_reg <= 1'b0;
			// only software clears this one
			if (buf_wr && engine_busy)
				write_collision_flag_reg <= 1'b1; // [RULE8] [RULE15] [RULE23]
			else if (ev_wr && pwdata[`I2M_EV_WRITE_COLLISION_FLAG])
				write_collision_flag_reg <= 1'b0;
		end
	end

	// read mux, captured in the setup phase so read data comes from a flop
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (paddr)
			`I2M_OFF_RELOAD: rdata_next[6:0] = rate_reload_reg;
			`I2M_OFF_CTRL2: begin
				rdata_next[`I2M_C2_START]   = start_req_reg;
				rdata_next[`I2M_C2_RESTART] = restart_req_reg;
				rdata_next[`I2M_C2_ACK_RECEIVED_STATUS] = ack_status_reg;
			end
			`I2M_OFF_STATUS: begin
				rdata_next[`I2M_ST_FULL]  = full_reg;
				rdata_next[`I2M_ST_START] = start_seen_reg;
			end
			`I2M_OFF_BUFFER: rdata_next[7:0] = buffer_reg;
			`I2M_OFF_EVENTS: begin
				rdata_next[`I2M_EV_PORT] = port_event_reg;
				rdata_next[`I2M_EV_COLL] = coll_event_reg;
				rdata_next[`I2M_EV_WRITE_COLLISION_FLAG] = write_collision_flag_reg;
			end
			default: rdata_next = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= rdata_next;
	end

	// open-drain pins: only ever pull low
	assign bus_clock_pin_out = 1'b0;
	assign bus_data_pin_out  = 1'b0;
	assign bus_clock_pin_oe  = scl_drv_reg;
	assign bus_data_pin_oe   = sda_drv_reg;

	a_start_launch: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
		state_reg == i2m_pkg::IDLE && start_req_reg && both_high |=> state_reg == i2m_pkg::ST_WAIT && brg.active)
		else $error("start did not launch counter");
	a_start_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
		start_done |=> !start_req_reg && sda_drv_reg && !brg.active)
		else $error("start end wrong");
	a_start_coll: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
		state_reg == i2m_pkg::ST_WAIT && !bus_clock_pin_in |=> state_reg == i2m_pkg::IDLE && coll_event_reg
		&& !start_req_reg && !sda_drv_reg) else $error("start collision not handled");
	a_write_collision_flag_busy: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		buf_wr && cond_busy |=> write_collision_flag_reg && $stable(buffer_reg)) else $error("busy buffer write accepted");
	a_ctrl_lock: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		ctrl_wr && cond_busy && !collide && !start_done && !restart_done |=>
		start_req_reg == $past(start_req_reg) && restart_req_reg == $past(restart_req_reg))
		else $error("control written while locked");
	a_restart_idle: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
		ctrl_wr && pwdata[`I2M_C2_RESTART] && state_reg != i2m_pkg::IDLE |=> !$rose(restart_req_reg))
		else $error("restart taken while busy");
	a_restart_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
		restart_done |=> !restart_req_reg && sda_drv_reg && port_event_reg) else $error("restart end wrong");
	a_restart_coll: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
		state_reg == i2m_pkg::RS_REL && brg.timeout && !bus_data_pin_in |=> state_reg == i2m_pkg::IDLE
		&& coll_event_reg && !restart_req_reg && !scl_drv_reg && !sda_drv_reg) else $error("restart collision not handled");
	a_full_set: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
		buf_wr && !engine_busy |=> full_reg && state_reg == i2m_pkg::TX_LOW && brg.active)
		else $error("buffer write did not launch byte");
	a_high_load: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		state_reg == i2m_pkg::TX_HWAIT && bus_clock_pin_in |-> !brg.active ##1 state_reg == i2m_pkg::TX_HIGH && brg.active)
		else $error("high phase not reloaded on clock high");
	a_bf_release: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
		state_reg == i2m_pkg::TX_HIGH && brg.timeout && bit_reg == `I2M_BIT_EIGHTH |=> !full_reg ##1 (!sda_drv_reg
		|| bus_clock_pin_in)) else $error("eighth edge did not release");
	a_ack_sample: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
		byte_done |=> ack_status_reg == $past(bus_data_pin_in)) else $error("ack status not sampled");
	a_byte_end: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
		byte_done |=> port_event_reg && scl_drv_reg && !sda_drv_reg && !brg.active && state_reg == i2m_pkg::IDLE)
		else $error("byte end wrong");
endmodule : i2m_top

// [testbench/i2m_slave_model.sv]
// partner model: i2c slave that acknowledges, stretches the clock and can hold either line low
`timescale 1ns/100ps
module i2m_slave_model (
	input  wire logic       pclk,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       ack_en,
	input  wire logic [7:0] stretch,
	input  wire logic       hold_scl,
	input  wire logic       hold_sda,
	output logic            scl_oe,
	output logic            sda_oe,
	output logic [7:0]      rx_byte
);
	logic       scl_q   = 1'b1;
	logic       sda_q   = 1'b1;
	logic       ack_drv = 1'b0;
	logic [3:0] bit_cnt = 4'h0;
	logic [7:0] st_cnt  = 8'h00;

	// lines sampled on pclk; a start condition restarts the bit count
	always @(posedge pclk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (st_cnt != 8'h00)
			st_cnt <= st_cnt - 8'h01;
		if (scl && scl_q && sda_q && !sda)
			bit_cnt <= 4'h0;
		else if (scl && !scl_q) begin
			if (bit_cnt < 4'h8)
				rx_byte <= {rx_byte[6:0], sda};
			bit_cnt <= bit_cnt + 4'h1;
		end else if (!scl && scl_q) begin
			// ack slot opens after the eighth fall and ends at the ninth
			ack_drv <= (bit_cnt == 4'h8) && ack_en;
			st_cnt  <= stretch;
			if (bit_cnt == 4'h9)
				bit_cnt <= 4'h0;
		end
	end

	// open drain: the model only ever pulls low, the pull-up does the rest
	assign scl_oe = hold_scl | (st_cnt != 8'h00);
	assign sda_oe = hold_sda | ack_drv;
endmodule : i2m_slave_model

// [testbench/i2m_top_tb_top.sv]
// self-checking bench for the i2c master engine
`timescale 1ns/100ps
`include "i2m_defines.svh"
module i2m_top_tb_top;
	localparam logic [7:0] a_rl = `I2M_OFF_RELOAD;
	localparam logic [7:0] a_c2 = `I2M_OFF_CTRL2;
	localparam logic [7:0] a_st = `I2M_OFF_STATUS;
	localparam logic [7:0] a_bf = `I2M_OFF_BUFFER;
	localparam logic [7:0] a_ev = `I2M_OFF_EVENTS;
	localparam int         roll = 2 * (8'h18 + 1);
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [7:0]  paddr, stretch, rx_byte;
	logic [31:0] pwdata, prdata, rd;
	logic        scl_oe, sda_oe, s_scl_oe, s_sda_oe, scl, sda, ack_en, hold_scl, hold_sda, scl_out, sda_out;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          hi_n, lo_n, min_hi, max_hi, max_lo;

	// wired-and lines with pull-ups
	assign scl = !((scl_oe && !scl_out) || s_scl_oe);
	assign sda = !((sda_oe && !sda_out) || s_sda_oe);

	i2m_top i2m_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_clock_pin_in(scl), .bus_clock_pin_out(scl_out), .bus_clock_pin_oe(scl_oe),
		.bus_data_pin_in(sda), .bus_data_pin_out(sda_out), .bus_data_pin_oe(sda_oe));
	i2m_slave_model i2m_slave_model_i (.pclk(pclk), .scl(scl), .sda(sda), .ack_en(ack_en),
		.stretch(stretch), .hold_scl(hold_scl), .hold_sda(hold_sda), .scl_oe(s_scl_oe),
		.sda_oe(s_sda_oe), .rx_byte(rx_byte));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// timeout and clock phase statistics; phases are recorded when they end
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			$display("BAD %0t timeout", $time);
			print_verdict();
		end
		if (scl) begin
			if (lo_n > max_lo)
				max_lo = lo_n;
			lo_n = 0;
			hi_n++;
		end else begin
			if (hi_n > 0 && hi_n < min_hi)
				min_hi = hi_n;
			if (hi_n > max_hi)
				max_hi = hi_n;
			hi_n = 0;
			lo_n++;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// one apb transfer; read data and error are taken at the edge that sees pready
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd      = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp, input string what);
		apb(1'b0, addr, 32'h0);
		check(rd & mask, exp, what);
	endtask : rd_chk

	// polls the event register; bounded so a missing event cannot hang the run
	task automatic wait_ev(input int idx);
		int n;
		n = 0;
		do begin
			apb(1'b0, a_ev, 32'h0);
			n++;
		end while (rd[idx] !== 1'b1 && n < 3000);
		check({31'h0, rd[idx]}, 32'h1, "event flag");
	endtask : wait_ev

	task automatic pins(input logic [1:0] exp, input string what);
		check({30'h0, scl_oe, sda_oe}, {30'h0, exp}, what);
	endtask : pins

	task automatic t_reset();
		rd_chk(a_rl, 32'hffffffff, {25'h0, `I2M_RELOAD_RST}, "reload reset");
		rd_chk(a_c2, 32'hffffffff, 32'h0, "ctrl2 reset");
		rd_chk(a_st, 32'hffffffff, 32'h0, "status reset");
		rd_chk(a_ev, 32'hffffffff, 32'h0, "events reset");
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, rd_err}, 32'h1, "unmapped error");
		check(rd, 32'h0, "unmapped data");
		$display("done reset values");
	endtask : t_reset

	task automatic t_start_coll();
		hold_scl <= 1'b1;
		hold_sda <= 1'b1;
		apb(1'b1, a_c2, 32'h1);
		wait_ev(`I2M_EV_COLL);
		rd_chk(a_c2, 32'h3, 32'h0, "start aborted");
		pins(2'b00, "lines released");
		hold_scl <= 1'b0;
		hold_sda <= 1'b0;
		apb(1'b1, a_ev, 32'h7);
		// another master pulls the clock low while the start still waits
		apb(1'b1, a_c2, 32'h1);
		repeat (5) @(posedge pclk);
		hold_scl <= 1'b1;
		wait_ev(`I2M_EV_COLL);
		rd_chk(a_c2, 32'h3, 32'h0, "start wait aborted");
		pins(2'b00, "data not driven");
		hold_scl <= 1'b0;
		apb(1'b1, a_ev, 32'h7);
		$display("done start collision");
	endtask : t_start_coll

	task automatic t_start();
		apb(1'b1, a_rl, 32'h18);
		apb(1'b1, a_c2, 32'h1);
		apb(1'b1, a_bf, 32'h5a);
		apb(1'b1, a_c2, 32'h2);
		rd_chk(a_c2, 32'h3, 32'h1, "ctrl2 locked");
		rd_chk(a_ev, 32'h1, 32'h0, "no early event");
		wait_ev(`I2M_EV_PORT);
		rd_chk(a_c2, 32'h3, 32'h0, "start cleared");
		rd_chk(a_st, 32'h8, 32'h8, "start seen");
		pins(2'b01, "data held low");
		rd_chk(a_ev, 32'h4, 32'h4, "write collision");
		apb(1'b1, a_ev, 32'h7);
		$display("done start");
	endtask : t_start

	// the first phase seen is the idle high left by start, so it is kept out
	task automatic send_byte(input logic [7:0] data, input logic ack, input logic [7:0] st);
		ack_en  <= ack;
		stretch <= st;
		hi_n   = -100000;
		lo_n   = 0;
		min_hi = 100000;
		max_hi = 0;
		max_lo = 0;
		apb(1'b1, a_bf, {24'h0, data});
		rd_chk(a_st, 32'h1, 32'h1, "buffer full");
		apb(1'b1, a_c2, 32'h2);
		rd_chk(a_c2, 32'h2, 32'h0, "restart ignored");
		wait_ev(`I2M_EV_PORT);
		check({24'h0, rx_byte}, {24'h0, data}, "byte on wire");
		rd_chk(a_c2, 32'h40, ack ? 32'h0 : 32'h40, "ack status");
		rd_chk(a_st, 32'h1, 32'h0, "full cleared");
		pins(2'b10, "clock held low");
		repeat (60) @(posedge pclk);
		pins(2'b10, "still held");
		apb(1'b1, a_ev, 32'h7);
	endtask : send_byte

	task automatic t_byte_rate();
		send_byte(8'ha6, 1'b1, 8'd0);
		check({31'h0, min_hi >= roll - 2}, 32'h1, "high phase");
		check({31'h0, max_hi + max_lo >= 2 * roll - 4 && max_hi + max_lo <= 2 * roll + 8}, 32'h1, "period");
		$display("done byte rate");
	endtask : t_byte_rate

	task automatic t_restart();
		apb(1'b1, a_c2, 32'h2);
		apb(1'b1, a_bf, 32'h33);
		apb(1'b1, a_c2, 32'h1);
		rd_chk(a_c2, 32'h3, 32'h2, "ctrl2 locked");
		rd_chk(a_ev, 32'h1, 32'h0, "no early event");
		rd_chk(a_bf, 32'hff, 32'ha6, "buffer kept");
		wait_ev(`I2M_EV_PORT);
		rd_chk(a_c2, 32'h3, 32'h0, "restart cleared");
		rd_chk(a_st, 32'h8, 32'h8, "start seen");
		pins(2'b01, "data held low");
		rd_chk(a_ev, 32'h4, 32'h4, "write collision");
		apb(1'b1, a_ev, 32'h7);
		$display("done restart");
	endtask : t_restart

	task automatic t_byte_stretch();
		send_byte(8'h3c, 1'b0, 8'd80);
		check({31'h0, max_lo >= 80}, 32'h1, "stretched low");
		check({31'h0, min_hi >= roll - 2}, 32'h1, "high after stretch");
		$display("done byte stretch");
	endtask : t_byte_stretch

	task automatic t_restart_coll();
		hold_sda <= 1'b1;
		apb(1'b1, a_c2, 32'h2);
		wait_ev(`I2M_EV_COLL);
		rd_chk(a_c2, 32'h3, 32'h0, "restart aborted");
		pins(2'b00, "lines released");
		hold_sda <= 1'b0;
		apb(1'b1, a_ev, 32'h7);
		$display("done restart collision");
	endtask : t_restart_coll

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	initial begin
		{psel, penable, pwrite, ack_en, hold_scl, hold_sda} = 6'h0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		stretch = 8'h00;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_start_coll();
		t_start();
		t_byte_rate();
		t_restart();
		t_byte_stretch();
		t_restart_coll();
		print_verdict();
	end
endmodule : i2m_top_tb_top
